// ---- hw/card_info_register_set.sv ----
`timescale 1ns/10ps
// Summary of operation
// - the three registers are read through their bus commands; the busy flag and both protect bits also drive output pins
// - a 32-bit operating_conditions word gives voltage profile and power-up flag
// - bit 31 stays low until the power-up routine ends, then high
// - bits 30:29 report 10b, sector addressing
// - voltage window ones in 23:15, zeros 14:8, one in bit 7
// - a 128-bit device_identity is returned during identification
// - identity holds maker, product name, revision, serial and date fields
// - specific data: structure code 3h, spec version 4h
// - async access 4Fh, clocked access in 100-clock units, bus clock 32h
// - command classes 8F5h, read block 9h, no partial or misaligned blocks
// - erase group 1Fh, multiplier 1Fh, device size FFFh, multiplier 7h
// - protect group 0Fh enabled; host writes permanent and temporary bits
// - write block 9h, write speed factor 2h, no partial write blocks
// - addresses are 512-byte sector numbers, capacity above 2 GB
module card_info_register_set #(
   parameter int POWERUP_CYCLES = card_info_pkg::POWERUP_CYCLES,
   parameter logic [7:0] MAKER_CODE = 8'h5a,           // arbitrary value
   parameter logic [1:0] PACKAGE_TYPE_CODE = 2'h0,     // arbitrary value
   parameter logic [7:0] OEM_APPLICATION_CODE = 8'h00, // arbitrary value
   parameter logic [47:0] PRODUCT_NAME = 48'h414243444546, // arbitrary value
   parameter logic [7:0] PRODUCT_REVISION = 8'h10,     // arbitrary value
   parameter logic [31:0] SERIAL_NUMBER = 32'h12345678,
   parameter logic [7:0] MANUFACTURE_DATE = 8'h11
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_card_clk,
   input wire logic i_cmd,
   output logic o_cmd,
   output logic o_cmd_oe,
   output logic o_powerup_done,
   output logic o_permanent_protect,
   output logic o_temporary_protect
);
   import card_info_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_GAP, ST_SEND} link_state_t;

   // ---------------------------------------------------------------
   // pin synchronisers and card clock edges
   // ---------------------------------------------------------------
   logic [2:0] clk_sync_q;
   logic [1:0] cmd_sync_q;
   logic rise;
   logic fall;
   logic cmd_bit;

   // two flops each before use; third clock flop only for the edge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_sync_q <= 3'h0;
         cmd_sync_q <= 2'h3;
      end else begin
         clk_sync_q <= {clk_sync_q[1:0], i_card_clk};
         cmd_sync_q <= {cmd_sync_q[0], i_cmd};
      end
   end

   // edges show up a few cycles late; the command bit carries the same delay
   assign rise = clk_sync_q[1] & ~clk_sync_q[2];
   assign fall = ~clk_sync_q[1] & clk_sync_q[2];
   assign cmd_bit = cmd_sync_q[1];

   // ---------------------------------------------------------------
   // power-up routine
   // ---------------------------------------------------------------
   logic [31:0] pwr_cnt_q;
   logic pwr_done_q;

   // busy flag reads low while this count runs; it restarts at every reset,
   // so a host that resets mid-run must poll the flag again
   // the counter parks at its last value, so it never wraps back to busy
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pwr_cnt_q <= 32'h0;
         pwr_done_q <= 1'b0;
      end else if (!pwr_done_q) begin
         if (pwr_cnt_q == 32'(POWERUP_CYCLES - 1)) begin
            pwr_done_q <= 1'b1;
         end else begin
            pwr_cnt_q <= pwr_cnt_q + 32'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // register contents
   // ---------------------------------------------------------------
   logic perm_q;
   logic temp_q;
   logic [31:0] op_cond;
   logic [119:0] ident_body;
   logic [119:0] spec_body;
   logic [127:0] ident_word;
   logic [127:0] spec_word;

   // sector mode always, since the array is larger than 2 GB;
   // the busy flag rides in the top bit
   assign op_cond = {pwr_done_q,
                     ACCESS_MODE_SECTOR,
                     OPCOND_RSVD_HI,
                     VOLT_HIGH_RANGE,
                     VOLT_MID_RANGE,
                     VOLT_LOW_RANGE,
                     OPCOND_RSVD_LO};

   // identity fields come from parameters so each build can carry its own
   assign ident_body = {MAKER_CODE,
                        6'h00,
                        PACKAGE_TYPE_CODE,
                        OEM_APPLICATION_CODE,
                        PRODUCT_NAME,
                        PRODUCT_REVISION,
                        SERIAL_NUMBER,
                        MANUFACTURE_DATE};

   // bit order from 127 downward; only the two protect cells can change
   assign spec_body = {STRUCTURE_CODE, // 127:126
                       SPEC_VERSION_CODE, // 125:122
                       2'h0, // 121:120
                       ASYNC_ACCESS_TIME, // 119:112
                       CLOCKED_ACCESS_TIME, // 111:104
                       MAX_BUS_CLOCK, // 103:96
                       COMMAND_CLASS_MASK, // 95:84
                       MAX_READ_BLOCK_LEN, // 83:80
                       1'b0, // 79 partial read
                       1'b0, // 78 write misalign
                       1'b0, // 77 read misalign
                       1'b0, // 76 no driver-stage register
                       2'h0, // 75:74
                       DEVICE_SIZE, // 73:62
                       CURRENT_CODE, // 61:59
                       CURRENT_CODE, // 58:56
                       CURRENT_CODE, // 55:53
                       CURRENT_CODE, // 52:50
                       SIZE_MULTIPLIER, // 49:47
                       ERASE_GROUP_SIZE, // 46:42
                       ERASE_GROUP_MULTIPLIER, // 41:37
                       PROTECT_GROUP_SIZE, // 36:32
                       PROTECT_GROUP_ENABLE, // 31
                       2'h0, // 30:29 default ecc
                       WRITE_SPEED_FACTOR, // 28:26
                       MAX_WRITE_BLOCK_LEN, // 25:22
                       1'b0, // 21 partial write
                       4'h0, // 20:17
                       1'b0, // 16 content protection
                       1'b0, // 15 file format group
                       1'b0, // 14 copy flag
                       perm_q, // 13
                       temp_q, // 12
                       2'h0, // 11:10 file format
                       2'h0}; // 9:8 ecc code

   // crc recomputed live, so it follows the protect bits
   assign ident_word = {ident_body, crc7_120(ident_body), 1'b1};
   assign spec_word = {spec_body, crc7_120(spec_body), 1'b1};

   // ---------------------------------------------------------------
   // command receiver and responder
   // ---------------------------------------------------------------
   link_state_t state_q;
   logic [46:0] frame_q;
   logic [7:0] bit_cnt_q;
   logic [1:0] gap_cnt_q;
   logic frame_done;
   logic frame_ok;
   logic [5:0] rx_index;
   logic [47:0] rx_head;
   logic rx_crc_ok;
   logic last_bit;
   logic want_short;
   logic want_long;
   logic load;
   logic [135:0] load_data;
   logic [7:0] resp_len_q;
   logic tx_bit;

   // ---------------------------------------------------------------
   // frame decode
   // ---------------------------------------------------------------
   // frame_done is the rising edge that brings in the end bit
   assign frame_done = (state_q == ST_RECV) && rise &&
                       (bit_cnt_q == 8'(CMD_FRAME_BITS - 1));
   // whole frame as it stands when the end bit arrives, start bit on top
   assign rx_head = {frame_q, cmd_bit};
   assign rx_index = rx_head[CMD_IDX_MSB:CMD_IDX_LSB];
   assign rx_crc_ok = (rx_head[7:1] == crc7_120({80'h0, rx_head[47:8]}));
   // a bad crc, direction or end bit drops the frame silently
   assign frame_ok = frame_done && cmd_bit && rx_head[CMD_DIR_BIT] && rx_crc_ok;
   assign want_short = frame_ok && (rx_index == CMD_SEND_OP_COND);
   assign want_long = frame_ok && ((rx_index == CMD_ALL_SEND_IDENTITY) ||
                                   (rx_index == CMD_SEND_SPECIFIC));
   // the last answer bit; shared by the sequencer and the shifter
   assign last_bit = (bit_cnt_q == resp_len_q - 8'h1);

   // state sequencing on card clock edges
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 8'h0;
         gap_cnt_q <= 2'h0;
         resp_len_q <= 8'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (rise && !cmd_bit) begin
                  state_q <= ST_RECV;
                  bit_cnt_q <= 8'h1;
               end
            end
            ST_RECV: begin
               if (frame_done) begin
                  state_q <= (want_short || want_long) ? ST_GAP : ST_IDLE;
                  gap_cnt_q <= 2'h0;
                  resp_len_q <= want_long ? 8'(RESP_LONG_BITS) : 8'(RESP_SHORT_BITS);
               end else if (rise) begin
                  bit_cnt_q <= bit_cnt_q + 8'h1;
               end
            end
            ST_GAP: begin
               // answer starts after the fixed turnaround, on a falling edge
               if (fall) begin
                  if (gap_cnt_q == 2'(RESP_GAP_CLKS - 1)) begin
                     state_q <= ST_SEND;
                     bit_cnt_q <= 8'h0;
                  end else begin
                     gap_cnt_q <= gap_cnt_q + 2'h1;
                  end
               end
            end
            ST_SEND: begin
               // one bit per card clock, the last one held until the closing fall
               if (fall) begin
                  if (last_bit) begin
                     state_q <= ST_IDLE;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 8'h1;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // incoming bits collect msb first
   // the receiver listens in idle too, so the start bit is already in place
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         frame_q <= 47'h0;
      end else if (rise && (state_q == ST_IDLE || state_q == ST_RECV)) begin
         frame_q <= {frame_q[45:0], cmd_bit};
      end
   end

   // protect bits: permanent one only sets and holds until the next reset, temporary follows the host
   // written from the command argument, so no data transfer is needed
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         perm_q <= 1'b0;
         temp_q <= 1'b0;
      end else if (frame_ok && rx_index == CMD_PROGRAM_SPECIFIC) begin
         perm_q <= perm_q | rx_head[CMD_ARG_LSB + ARG_PERM_BIT];
         temp_q <= rx_head[CMD_ARG_LSB + ARG_TEMP_BIT];
      end
   end

   // the answer is frozen into the shifter when the command ends, so the busy
   // bit is the one seen as the end bit arrives
   assign load = frame_done && (want_short || want_long);
   assign load_data = want_long ?
                      {RESP_HEADER, (rx_index == CMD_SEND_SPECIFIC) ? spec_word : ident_word} :
                      {RESP_HEADER, op_cond, 8'hff, 88'h0};

   // one shifter serves both lengths; a short answer simply stops early
   resp_shifter #(
      .W(RESP_LONG_BITS)
   ) u_shift (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_load(load),
      .i_data(load_data),
      .i_shift(fall && state_q == ST_SEND && !last_bit),
      .o_bit(tx_bit)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // the shifter is loaded before the turnaround, so the line is held high
   // until the answer really starts; otherwise the start bit would leak early
   assign o_cmd = o_cmd_oe ? tx_bit : 1'b1;
   assign o_cmd_oe = (state_q == ST_SEND);
   assign o_powerup_done = pwr_done_q;
   assign o_permanent_protect = perm_q;
   assign o_temporary_protect = temp_q;
endmodule

// ---- hw/card_info_pkg.sv ----
package card_info_pkg;
   // ---------------------------------------------------------------
   // clock, timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int POWERUP_TIME_US = 1000;
   localparam int POWERUP_CYCLES = POWERUP_TIME_US * CLK_MHZ;
   localparam int RESP_GAP_CLKS = 2;

   // ---------------------------------------------------------------
   // command frame layout
   // ---------------------------------------------------------------
   localparam int CMD_FRAME_BITS = 48;
   localparam int CMD_DIR_BIT = 46;
   localparam int CMD_IDX_MSB = 45;
   localparam int CMD_IDX_LSB = 40;
   localparam int CMD_ARG_MSB = 39;
   localparam int CMD_ARG_LSB = 8;
   localparam int RESP_SHORT_BITS = 48;
   localparam int RESP_LONG_BITS = 136;
   localparam logic [7:0] RESP_HEADER = 8'h3f;
   localparam logic [5:0] CMD_SEND_OP_COND = 6'h01;
   localparam logic [5:0] CMD_ALL_SEND_IDENTITY = 6'h02;
   localparam logic [5:0] CMD_SEND_SPECIFIC = 6'h09;
   localparam logic [5:0] CMD_PROGRAM_SPECIFIC = 6'h1b;
   localparam int ARG_PERM_BIT = 1;
   localparam int ARG_TEMP_BIT = 0;

   // ---------------------------------------------------------------
   // operating_conditions fields
   // ---------------------------------------------------------------
   localparam int OPCOND_BUSY_BIT = 31;
   localparam logic [1:0] ACCESS_MODE_SECTOR = 2'h2;
   localparam logic [4:0] OPCOND_RSVD_HI = 5'h00;
   localparam logic [8:0] VOLT_HIGH_RANGE = 9'h1ff;
   localparam logic [6:0] VOLT_MID_RANGE = 7'h00;
   localparam logic VOLT_LOW_RANGE = 1'b1;
   localparam logic [6:0] OPCOND_RSVD_LO = 7'h00;

   // ---------------------------------------------------------------
   // device_specific_data fields
   // ---------------------------------------------------------------
   localparam logic [1:0] STRUCTURE_CODE = 2'h3;
   localparam logic [3:0] SPEC_VERSION_CODE = 4'h4;
   localparam logic [7:0] ASYNC_ACCESS_TIME = 8'h4f;
   localparam logic [7:0] CLOCKED_ACCESS_TIME = 8'h01;
   localparam logic [7:0] MAX_BUS_CLOCK = 8'h32;
   localparam logic [11:0] COMMAND_CLASS_MASK = 12'h8f5;
   localparam logic [3:0] MAX_READ_BLOCK_LEN = 4'h9;
   localparam logic [11:0] DEVICE_SIZE = 12'hfff;
   localparam logic [2:0] CURRENT_CODE = 3'h7;
   localparam logic [2:0] SIZE_MULTIPLIER = 3'h7;
   localparam logic [4:0] ERASE_GROUP_SIZE = 5'h1f;
   localparam logic [4:0] ERASE_GROUP_MULTIPLIER = 5'h1f;
   localparam logic [4:0] PROTECT_GROUP_SIZE = 5'h0f;
   localparam logic PROTECT_GROUP_ENABLE = 1'b1;
   localparam logic [2:0] WRITE_SPEED_FACTOR = 3'h2;
   localparam logic [3:0] MAX_WRITE_BLOCK_LEN = 4'h9;

   // crc7, polynomial x^7 + x^3 + 1, zero seed, msb first
   function automatic logic [6:0] crc7_120(input logic [119:0] data);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      fb = 1'b0;
      for (int i = 119; i >= 0; i--) begin
         fb = data[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
      end
      return c;
   endfunction
endpackage

// ---- hw/resp_shifter.sv ----
`timescale 1ns/10ps
// parallel-load shift register, msb leaves first
module resp_shifter #(
   parameter int W = 136
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [W-1:0] i_data,
   input wire logic i_shift,
   output logic o_bit
);
   logic [W-1:0] sh_q;

   // load beats shift so a new answer never mixes with the old one
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sh_q <= '1;
      end else if (i_load) begin
         sh_q <= i_data;
      end else if (i_shift) begin
         sh_q <= {sh_q[W-2:0], 1'b1};
      end
   end

   assign o_bit = sh_q[W-1];
endmodule

// ---- verification/card_info_chk.sv ----
`timescale 1ns/10ps
module card_info_chk #(
   parameter int POWERUP_CYCLES = 20
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_card_clk,
   input wire logic i_cmd,
   input wire logic o_cmd,
   input wire logic o_cmd_oe,
   input wire logic o_powerup_done,
   input wire logic o_permanent_protect,
   input wire logic o_temporary_protect
);
   // ----------------
   // helper counters
   // ----------------
   logic card_q;
   int unsigned rises;
   int unsigned up_cnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // raw card clock rises while answering; cycles since reset, capped
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         card_q <= 1'b0;
         rises <= 0;
         up_cnt <= 0;
      end else begin
         card_q <= i_card_clk;
         rises <= !o_cmd_oe ? 0 : ((i_card_clk && !card_q) ? rises + 1 : rises);
         if (up_cnt < POWERUP_CYCLES + 2) up_cnt <= up_cnt + 1;
      end
   end
   // start bit low for the first 8 clocks of an answer; the direction bit is not checked
   sequence start_low;
      (o_cmd_oe && !o_cmd)[*8];
   endsequence
   // ------------
   // assertions
   // ------------
   chk_idle_high: assert property (!o_cmd_oe |-> o_cmd) else $error("idle line low");
   chk_start_bits: assert property ($rose(o_cmd_oe) |-> start_low) else $error("no start");
   chk_answer_len: assert property ($fell(o_cmd_oe) |-> rises == 48 || rises == 136)
      else $error("answer length wrong");
   chk_bits_on_fall: assert property (o_cmd_oe && $changed(o_cmd) |-> !i_card_clk)
      else $error("answer bit moved while card clock high");
   chk_powerup_early: assert property (up_cnt + 1 < POWERUP_CYCLES |-> !o_powerup_done)
      else $error("power-up flag early");
   chk_powerup_late: assert property (up_cnt > POWERUP_CYCLES + 1 |-> o_powerup_done)
      else $error("power-up flag late");
   chk_perm_sticky: assert property (o_permanent_protect |=> o_permanent_protect)
      else $error("permanent protect cleared");
   chk_protect_quiet: assert property (o_cmd_oe |-> $stable({o_permanent_protect,
      o_temporary_protect})) else $error("protect bits moved during answer");
   chk_reset_state: assert property (disable iff (1'b0) !i_nrst |-> o_cmd && !o_cmd_oe
      && !o_powerup_done && !o_permanent_protect && !o_temporary_protect)
      else $error("outputs wrong in reset");
endmodule

// ---- verification/card_host.sv ----
`timescale 1ns/10ps
module card_host (
   input wire logic i_clk,
   input wire logic i_dev_cmd,
   input wire logic i_dev_oe,
   output logic o_card_clk,
   output logic o_cmd_line
);
   // ------------------
   // command line host
   // ------------------
   logic drv = 1'b0;
   logic dbit = 1'b1;
   initial o_card_clk = 1'b0;
   // released line goes to the pull-up level
   assign o_cmd_line = i_dev_oe ? i_dev_cmd : (drv ? dbit : 1'b1);
   // crc7 over the low n bits, msb first
   function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
      logic [6:0] c;
      c = 7'h00;
      for (int i = n - 1; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
      end
      return c;
   endfunction
   // card clock is 8 system clocks and stands low between transfers
   task automatic tick(input logic lvl);
      repeat (4) @(posedge i_clk);
      o_card_clk <= lvl;
   endtask
   // frame changes on falling edges; answer taken half a system clock after each card clock rise
   task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic bad,
                       output logic [135:0] resp, output int n);
      logic [47:0] f;
      logic done;
      f = {2'b01, idx, arg, 8'h01};
      f[7:1] = crc7({80'h0, f[47:8]}, 40) ^ {6'h00, bad};
      resp = '0;
      n = 0;
      done = 1'b0;
      for (int i = 47; i >= 0; i--) begin
         drv <= 1'b1;
         dbit <= f[i];
         tick(1'b1);
         tick(1'b0);
      end
      drv <= 1'b0;
      for (int k = 0; k < 150 && !done; k++) begin
         tick(1'b1);
         @(negedge i_clk);
         if (i_dev_oe) begin
            resp = {resp[134:0], o_cmd_line};
            n++;
         end else if (n > 0) done = 1'b1;
         tick(1'b0);
      end
   endtask
endmodule

// ---- verification/card_info_register_set_bench.sv ----
`timescale 1ns/10ps
module card_info_register_set_bench;
   localparam int PU = 600;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b1;
   logic card_clk;
   logic cmd_line;
   logic o_cmd;
   logic o_cmd_oe;
   logic pd;
   logic pp;
   logic tp;
   logic [135:0] r;
   int n;
   int fail_count = 0;
   int checks_done = 0;
   // --------
   // harness
   // --------
   always #12.5 i_clk = ~i_clk;
   card_info_register_set #(.POWERUP_CYCLES(PU)) i_card_info_register_set (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_card_clk(card_clk), .i_cmd(cmd_line),
      .o_cmd(o_cmd), .o_cmd_oe(o_cmd_oe), .o_powerup_done(pd),
      .o_permanent_protect(pp), .o_temporary_protect(tp));
   card_host i_card_host (.i_clk(i_clk), .i_dev_cmd(o_cmd), .i_dev_oe(o_cmd_oe),
      .o_card_clk(card_clk), .o_cmd_line(cmd_line));
   // ----------------
   // expected values
   // ----------------
   function automatic logic [135:0] opcond_ans(input logic busy);
      return {88'h0, 8'h3f, busy, 2'b10, 5'h00, 9'h1ff, 7'h00, 1'b1, 7'h00, 8'hff};
   endfunction
   function automatic logic [135:0] long_ans(input logic [127:0] v);
      return {8'h3f, v[127:8], i_card_host.crc7(v[127:8], 120), 1'b1};
   endfunction
   function automatic logic [127:0] ident();
      return {8'h5a, 8'h00, 8'h00, 48'h414243444546, 8'h10, 32'h12345678, 8'h11, 8'h00};
   endfunction
   function automatic logic [127:0] spec(input logic p, input logic t);
      return {2'h3, 4'h4, 2'h0, 8'h4f, 8'h01, 8'h32, 12'h8f5, 4'h9, 6'h00, 12'hfff, 15'h7fff,
         5'h1f, 5'h1f, 5'h0f, 1'b1, 2'h0, 3'h2, 4'h9, 5'h00, 3'h0, p, t, 12'h000};
   endfunction
   task automatic check(input logic [135:0] seen, input logic [135:0] want);
      checks_done++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, seen, want);
      end
   endtask
   task automatic go(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
      i_card_host.xfer(idx, arg, bad, r, n);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ----------
   // scenarios
   // ----------
   initial begin
      logic [31:0] a;
      logic pe;
      a = $urandom(32'he4a3dd4d);
      pe = 1'b0;
      // a real falling edge, so the asynchronous reset acts before the first clock
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk);
      // first answer still busy, flag up by the end of it
      go(6'h01, $urandom, 1'b0);
      check(r, opcond_ans(1'b0));
      check(136'(pd), 136'h1);
      go(6'h01, $urandom, 1'b0);
      check(r, opcond_ans(1'b1));
      go(6'h02, $urandom, 1'b0);
      check(r, long_ans(ident()));
      // permanent bit set once then written low, temporary follows each write
      for (int i = 0; i < 6; i++) begin
         a = $urandom;
         a[1] = (i == 2);
         pe = pe | a[1];
         go(6'h1b, a, 1'b0);
         check(136'(n), 136'h0);
         check(136'({pp, tp}), 136'({pe, a[0]}));
         go(6'h09, $urandom, 1'b0);
         check(r, long_ans(spec(pe, a[0])));
      end
      // damaged frame and unused index get no answer
      go(6'h09, $urandom, 1'b1);
      check(136'(n), 136'h0);
      go(6'h0d, $urandom, 1'b0);
      check(136'(n), 136'h0);
      // reset mid-run clears protect bits and restarts power-up
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      check(136'({pd, pp, tp}), 136'h0);
      go(6'h01, $urandom, 1'b0);
      check(r, opcond_ans(1'b0));
      results();
   end
   // eighteen transfers take under 30000 cycles, so this only cuts a hang
   initial begin
      repeat (60000) @(posedge i_clk);
      fail_count++;
      results();
   end
endmodule
bind card_info_register_set card_info_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_card_clk(i_card_clk), .i_cmd(i_cmd), .o_cmd(o_cmd),
   .o_cmd_oe(o_cmd_oe), .o_powerup_done(o_powerup_done),
   .o_permanent_protect(o_permanent_protect), .o_temporary_protect(o_temporary_protect));
